// file: task_map_pkg.sv
// shared constants and types for the task map switch control
package task_map_pkg;
  localparam int TASK_W       = 5;
  localparam int PAGE_W       = 5;
  localparam int PHYS_W       = 10;
  localparam int FUSE_W       = 3;
  localparam int MAP_DEPTH    = 1024;
  localparam int MAP_AW       = 10;
  localparam int HADDR_W      = 12;

  localparam logic [TASK_W-1:0] TASK_SUPER    = 5'h00;
  localparam logic [TASK_W-1:0] TASK_TRANSFER = 5'h01;
  localparam logic [TASK_W-1:0] TASK_RESET    = 5'h00;
  localparam logic [FUSE_W-1:0] FUSE_RESET    = 3'h0;

  localparam logic [HADDR_W-1:0] OFF_ACTIVE_TASK = 12'h000;
  localparam logic [HADDR_W-1:0] OFF_FUSE        = 12'h004;
  localparam logic [HADDR_W-1:0] OFF_STATUS      = 12'h008;
  localparam logic [HADDR_W-1:0] OFF_ACCESS_KEY  = 12'h00c;
  localparam logic [HADDR_W-1:0] OFF_MAP_BASE    = 12'h800;

  localparam int ST_SYS_BIT   = 0;
  localparam int ST_FUSE_BIT  = 1;
  localparam int ST_CYC_LSB   = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    CYC_RUN      = 2'b00,
    CYC_INT_ACK  = 2'b01,
    CYC_SYNC_ACK = 2'b10,
    CYC_GRANT    = 2'b11
  } cycle_e;

  typedef struct packed {
    logic [TASK_W-1:0] task_num;
    logic [PAGE_W-1:0] page;
  } map_req_s;

  typedef struct packed {
    logic [PHYS_W-2:0] page_bits;
    logic              phys_addr_top_bit;
  } map_res_s;
endpackage : task_map_pkg

// file: map_ram.sv
// synchronous lookup memory with registered read data
`timescale 1ns/10ps
module map_ram #(
  parameter int DW = 10,
  parameter int AW = 10
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : map_ram

// file: task_map_switch_control.sv
// task selection, fuse counter, lookup mapping and ahb-lite registers
// Function
// - vector fetch forces task zero
// - acknowledge sets sticky system flag
// - system flag set maps with task zero, except during bus grant
// - bus grant maps with task one
// - leaving grant restores previous task immediately
// - halt treated same as bus grant
// - decode both status lines every cycle
// - fuse write loads 3-bit down counter
// - underflow clears flag, selects active task
// - count only non-transfer, non-dead cycles
// - page plus task gives 10-bit result
// - active task is 5-bit held register
// - register writes only while flag set
// - reset sets flag, disables fuse, clears keys
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module task_map_switch_control
  import task_map_pkg::*;
#(
  parameter int FUSE_BITS = FUSE_W
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                cpu_cycle,
  input  wire logic                bus_available,
  input  wire logic                bus_state_status,
  input  wire logic [PAGE_W-1:0]   logical_page,
  output logic      [PHYS_W-1:0]   phys_page_ff,
  output logic      [TASK_W-1:0]   cur_task_ff,
  output logic                     sys_flag_ff,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata_ff,
  output logic                     hreadyout,
  output logic                     hresp
);
  // status pins cross from the processor domain
  logic       ba_meta_ff, ba_sync_ff, bs_meta_ff, bs_sync_ff;
  logic       ba_prev_ff;
  logic       fuse_run_ff;
  logic [FUSE_BITS-1:0] fuse_cnt_ff;
  logic [TASK_W-1:0]    active_task_ff;
  logic [TASK_W-1:0]    access_key_ff;
  logic                 ap_write_ff;
  logic                 ap_read_ff;
  logic [HADDR_W-1:0]   ap_addr_ff;
  logic                 rd_map_ff;
  logic [HADDR_W-1:0]   rd_addr_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ba_meta_ff <= 1'b0;
      ba_sync_ff <= 1'b0;
      bs_meta_ff <= 1'b0;
      bs_sync_ff <= 1'b0;
    end else begin
      ba_meta_ff <= bus_available;
      ba_sync_ff <= ba_meta_ff;
      bs_meta_ff <= bus_state_status;
      bs_sync_ff <= bs_meta_ff;
    end
  end

  function automatic cycle_e decode_cycle(input logic ba, input logic bs);
    return cycle_e'({ba, bs});
  endfunction : decode_cycle

  wire cycle_e cyc_kind    = decode_cycle(ba_sync_ff, bs_sync_ff);
  wire logic   is_grant    = (cyc_kind == CYC_GRANT);
  wire logic   is_int_ack  = (cyc_kind == CYC_INT_ACK);
  // dead cycle right after the bus is handed back must not be counted
  wire logic   count_ok    = cpu_cycle && !ba_sync_ff && !ba_prev_ff;
  wire logic   fuse_under  = fuse_run_ff && count_ok && (fuse_cnt_ff == '0);

  // ahb-lite slave, zero wait states on writes, one on reads, always okay
  wire logic        ap_valid   = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire logic        wr_active  = ap_write_ff && sys_flag_ff;
  wire logic        wr_task    = wr_active && (ap_addr_ff == OFF_ACTIVE_TASK);
  wire logic        wr_fuse    = wr_active && (ap_addr_ff == OFF_FUSE);
  wire logic        wr_akey    = wr_active && (ap_addr_ff == OFF_ACCESS_KEY);
  wire logic        in_map_w   = ap_addr_ff[HADDR_W-1] && (ap_addr_ff[1:0] == 2'h0);
  wire logic        wr_map     = wr_active && in_map_w && (ap_addr_ff[HADDR_W-2:7] == '0);
  wire logic        rd_in_map  = haddr[HADDR_W-1] && (haddr[HADDR_W-2:7] == '0);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ap_write_ff <= 1'b0;
      ap_read_ff  <= 1'b0;
      ap_addr_ff  <= '0;
    end else begin
      ap_write_ff <= ap_valid && hwrite;
      ap_read_ff  <= ap_valid && !hwrite;
      ap_addr_ff  <= haddr[HADDR_W-1:0];
    end
  end

  // sticky flag: acknowledge set wins over fuse underflow clear
  wire logic nxt_sys_flag = is_int_ack ? 1'b1 : (fuse_under ? 1'b0 : sys_flag_ff);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sys_flag_ff <= 1'b1;
      ba_prev_ff  <= 1'b0;
    end else begin
      sys_flag_ff <= nxt_sys_flag;
      if (cpu_cycle) begin
        ba_prev_ff <= ba_sync_ff;
      end
    end
  end

  // fuse counter: a write reloads even mid-count
  wire logic [FUSE_BITS-1:0] fuse_dec = fuse_cnt_ff - 1'b1;
  wire logic [FUSE_BITS-1:0] nxt_fuse_cnt =
    wr_fuse ? hwdata[FUSE_BITS-1:0] :
    (fuse_run_ff && count_ok) ? fuse_dec : fuse_cnt_ff;
  wire logic nxt_fuse_run = wr_fuse ? 1'b1 : (fuse_under ? 1'b0 : fuse_run_ff);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fuse_cnt_ff <= FUSE_BITS'(FUSE_RESET);
      fuse_run_ff <= 1'b0;
    end else begin
      fuse_cnt_ff <= nxt_fuse_cnt;
      fuse_run_ff <= nxt_fuse_run;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_task_ff <= TASK_RESET;
      access_key_ff  <= TASK_RESET;
    end else begin
      if (wr_task) begin
        active_task_ff <= hwdata[TASK_W-1:0];
      end
      if (wr_akey) begin
        access_key_ff <= hwdata[TASK_W-1:0];
      end
    end
  end

  // grant is evaluated live so a stolen-back cycle leaves task one at once
  wire logic [TASK_W-1:0] sel_task =
    is_grant ? TASK_TRANSFER :
    (is_int_ack || sys_flag_ff) ? TASK_SUPER :
    active_task_ff;

  // lookup memory: mapping read each cycle unless a software read takes the port, writes from software
  wire map_req_s map_q   = '{task_num: sel_task, page: logical_page};
  wire map_req_s map_wq  = '{task_num: access_key_ff, page: ap_addr_ff[6:2]};
  wire map_req_s map_rq  = '{task_num: access_key_ff, page: haddr[6:2]};
  wire logic             sw_read = ap_valid && !hwrite && rd_in_map;
  wire logic [MAP_AW-1:0] ram_raddr = sw_read ? MAP_AW'(map_rq) : MAP_AW'(map_q);
  logic [PHYS_W-1:0] ram_rdata;

  map_ram #(
    .DW (PHYS_W),
    .AW (MAP_AW)
  ) u_map_ram (
    .clk   (clk),
    .we    (wr_map),
    .waddr (MAP_AW'(map_wq)),
    .wdata (hwdata[PHYS_W-1:0]),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );

  // software reads of the map range steal one mapping lookup; phys output holds then
  logic map_cycle_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      map_cycle_ff <= 1'b0;
      cur_task_ff  <= TASK_SUPER;
      rd_map_ff    <= 1'b0;
      rd_addr_ff   <= '0;
    end else begin
      map_cycle_ff <= !sw_read;
      cur_task_ff  <= sel_task;
      rd_map_ff    <= sw_read;
      rd_addr_ff   <= haddr[HADDR_W-1:0];
    end
  end

  wire map_res_s phys_res = map_res_s'(ram_rdata);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phys_page_ff <= '0;
    end else if (map_cycle_ff) begin
      phys_page_ff <= phys_res;
    end
  end

  wire logic [31:0] status_word = {{(32-ST_CYC_LSB-2){1'b0}}, cyc_kind,
                                   fuse_run_ff, sys_flag_ff};
  wire logic [31:0] reg_rdata =
    (rd_addr_ff == OFF_ACTIVE_TASK) ? 32'(active_task_ff) :
    (rd_addr_ff == OFF_FUSE)        ? 32'(fuse_cnt_ff) :
    (rd_addr_ff == OFF_STATUS)      ? status_word :
    (rd_addr_ff == OFF_ACCESS_KEY)  ? 32'(access_key_ff) : 32'h0000_0000;

  // read data registered one cycle after the data phase starts
  logic rd_pend_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_pend_ff <= 1'b0;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      rd_pend_ff <= ap_valid && !hwrite;
      if (rd_pend_ff) begin
        hrdata_ff <= rd_map_ff ? 32'(ram_rdata) : reg_rdata;
      end
    end
  end

  logic ready_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ready_ff <= 1'b1;
    end else begin
      ready_ff <= !(ap_valid && !hwrite) || rd_pend_ff;
    end
  end

  // ready comes straight from its flop; the read wait state lives in ready_ff
  assign hreadyout = ready_ff;
  assign hresp     = 1'b0;

  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:HADDR_W], ap_read_ff};
endmodule : task_map_switch_control

// file: task_map_checker.sv
// port assertions for the task map switch control
`timescale 1ns/10ps
module task_map_checker
  import task_map_pkg::*;
#(
  parameter int FUSE_BITS = FUSE_W
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              cpu_cycle,
  input wire logic              bus_available,
  input wire logic              bus_state_status,
  input wire logic [PHYS_W-1:0] phys_page_ff,
  input wire logic [TASK_W-1:0] cur_task_ff,
  input wire logic              sys_flag_ff,
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire grant = bus_available && bus_state_status;
  wire ack   = !bus_available && bus_state_status;
  wire take  = hsel && hready && htrans == HTRANS_NONSEQ;
  // four samples cover the two-flop sync plus the task register
  sequence s_grant; grant [*4]; endsequence
  sequence s_ack; ack [*4]; endsequence
  property p_grant; s_grant |=> cur_task_ff == TASK_TRANSFER; endproperty
  a_grant: assert property (p_grant) else $error("grant not on transfer task");
  property p_ack; s_ack |=> sys_flag_ff && cur_task_ff == TASK_SUPER; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not latched");
  property p_flag_task; (sys_flag_ff && !grant) [*4] |-> cur_task_ff == TASK_SUPER; endproperty
  a_flag_task: assert property (p_flag_task) else $error("flag not on task zero");
  property p_reset;
    disable iff (1'b0) !reset_n |=> sys_flag_ff && cur_task_ff == TASK_SUPER && phys_page_ff == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_fall; $fell(sys_flag_ff) |-> $past(cpu_cycle); endproperty
  a_fall: assert property (p_fall) else $error("flag cleared off a cycle");
  property p_hold_ba; bus_available [*4] |-> !$fell(sys_flag_ff); endproperty
  a_hold_ba: assert property (p_hold_ba) else $error("flag cleared while bus away");
  property p_write; take && hwrite |=> hreadyout; endproperty
  a_write: assert property (p_write) else $error("write stalled");
  property p_read; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_read: assert property (p_read) else $error("read wait wrong");
endmodule : task_map_checker
bind task_map_switch_control task_map_checker #(.FUSE_BITS(FUSE_BITS)) chk (
  .clk(clk), .reset_n(reset_n), .cpu_cycle(cpu_cycle), .bus_available(bus_available),
  .bus_state_status(bus_state_status), .phys_page_ff(phys_page_ff), .cur_task_ff(cur_task_ff),
  .sys_flag_ff(sys_flag_ff), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout));

// file: cpu_status_model.sv
// processor bus status model, one bus cycle per clk or per two when slow
`timescale 1ns/10ps
module cpu_status_model
  import task_map_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              slow,
  input  wire cycle_e            code,
  input  wire logic [PAGE_W-1:0] page,
  output logic                   cpu_cycle,
  output logic                   bus_available,
  output logic                   bus_state_status,
  output logic      [PAGE_W-1:0] logical_page
);
  logic phase_ff = 1'b0;
  initial {bus_available, bus_state_status, logical_page} = '0;
  assign cpu_cycle = !slow || phase_ff;
  // status changes only at a bus cycle boundary, so no dead cycle mid-status
  always @(posedge clk) begin
    phase_ff <= slow && !phase_ff;
    if (cpu_cycle) begin
      {bus_available, bus_state_status} <= code;
      logical_page <= page;
    end
  end
endmodule : cpu_status_model

// file: task_map_switch_control_tb.sv
// self-checking bench for the task map switch control
`timescale 1ns/10ps
module task_map_switch_control_tb
  import task_map_pkg::*;
;
  typedef struct packed {cycle_e code; logic flag; logic [TASK_W-1:0] tsk;} row_s;
  logic clk = 0, reset_n = 0, slow = 0, hsel = 0, hwrite = 0;
  cycle_e code = CYC_RUN;
  logic [31:0] haddr = '0, hwdata = '0, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire cpu_cycle, ba, bs, hreadyout, flag, resp;
  wire [PAGE_W-1:0] lpage;
  wire [PHYS_W-1:0] phys;
  wire [TASK_W-1:0] tsk;
  wire [31:0] rdata;
  int fails = 0, total_checks = 0, cyc = 0;
  row_s rows [7] = '{'{CYC_RUN, 1'b0, 5'h05}, '{CYC_GRANT, 1'b0, 5'h01},
    '{CYC_RUN, 1'b0, 5'h05}, '{CYC_SYNC_ACK, 1'b0, 5'h05}, '{CYC_GRANT, 1'b0, 5'h01},
    '{CYC_INT_ACK, 1'b1, 5'h00}, '{CYC_RUN, 1'b1, 5'h00}};
  cpu_status_model cpu (.clk(clk), .slow(slow), .code(code), .page(5'h03), .cpu_cycle(cpu_cycle),
    .bus_available(ba), .bus_state_status(bs), .logical_page(lpage));
  task_map_switch_control #(.FUSE_BITS(FUSE_W)) dut (.clk(clk), .reset_n(reset_n),
    .cpu_cycle(cpu_cycle), .bus_available(ba), .bus_state_status(bs), .logical_page(lpage),
    .phys_page_ff(phys), .cur_task_ff(tsk), .sys_flag_ff(flag), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata_ff(rdata), .hreadyout(hreadyout), .hresp(resp));
  always #20 clk = ~clk;
  // run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  // hready is fed back, so the wait ends only when the slave answers
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    // start on an edge so every request leaves right after a rising edge
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = rdata;
    check("hresp", 32'h0, {31'h0, resp});
  endtask : bus
  initial begin
    tick(2);
    reset_n <= 1'b1;
    bus(1, OFF_ACTIVE_TASK, 32'h5);
    bus(1, OFF_ACCESS_KEY, 32'h5);
    bus(1, OFF_MAP_BASE + 12'h00c, 32'h2a5);
    bus(0, OFF_ACTIVE_TASK, 0);
    check("active task", 32'h5, q);
    check("flag", 1, flag);
    bus(1, OFF_FUSE, 32'h1);
    tick(1);
    #1 check("flag counting", 1, flag);
    tick(1);
    #1 check("flag underflow", 0, flag);
    tick(4);
    #1 check("mapped page", 10'h2a5, phys);
    bus(1, OFF_ACTIVE_TASK, 32'h7);
    bus(0, OFF_ACTIVE_TASK, 0);
    check("locked task", 32'h5, q);
    bus(0, 12'h010, 32'h0);
    check("unmapped", 32'h0, q);
    bus(0, OFF_MAP_BASE + 12'h00c, 0);
    check("map read", 32'h2a5, q);
    $display("test setup and fuse done");
    slow <= 1'b1;
    foreach (rows[i]) begin
      code <= rows[i].code;
      tick(8);
      #1 check("task", rows[i].tsk, tsk);
      check("flag", rows[i].flag, flag);
    end
    $display("test status rows done");
    slow <= 1'b0;
    code <= CYC_GRANT;
    // grant must reach the synchronised status before the fuse write lands
    tick(4);
    bus(1, OFF_FUSE, 32'h0);
    tick(10);
    #1 check("halt flag", 1, flag);
    check("halt task", TASK_TRANSFER, tsk);
    bus(0, OFF_STATUS, 0);
    check("status", {28'h0, CYC_GRANT, 2'b11}, q);
    code <= CYC_RUN;
    tick(8);
    #1 check("resume task", 32'h5, tsk);
    check("resume flag", 0, flag);
    tick(1);
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    #1 check("reset task", TASK_SUPER, tsk);
    bus(0, OFF_ACTIVE_TASK, 0);
    check("reset active", 32'h0, q);
    $display("test halt and reset done");
    conclude();
  end
endmodule : task_map_switch_control_tb
